/* logic/ecmc_top.sv */
`timescale 1ns/1ps
module ecmc_top (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic resetn_in,
	// AXI4-Lite write channels.
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read channels.
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Timer side, same clock.
	input wire logic compare_match_in,
	input wire logic pwm_raw_in,
	input wire logic pwm_comp_in,
	// Capture pin, asynchronous.
	input wire logic capture_pin_in,
	// Timer controls.
	output logic capture_strobe_out,
	output logic special_event_out,
	output logic pwm_enable_out,
	output logic [9:0] duty_value_out,
	// Unit pins: level and enable.
	output logic output_a_out,
	output logic output_b_out,
	output logic output_c_out,
	output logic output_d_out,
	output logic [3:0] output_own_out,
	// Interrupt.
	output logic irq_out
);
	logic [7:0] ctrl_r; // Mode control register.
	logic [7:0] duty_r; // Duty high register.
	logic [0:0] stat_r; // Sticky unit interrupt flag.
	logic [0:0] mask_r; // Interrupt mask.
	logic [3:0] mode_q_r; // Mode seen in the last cycle.
	logic cmp_level_r; // Compare output level.
	logic aw_ok_r; // Write address held.
	logic [7:0] aw_addr_r;
	logic w_ok_r; // Write data held.
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [3:0] mode; // Mode field.
	logic mode_chg; // Mode differs from the last cycle.
	logic is_cap; // A capture mode is selected.
	logic is_cmp; // A compare mode is selected.
	logic is_pwm; // A PWM mode is selected.
	logic cap_evt; // Capture pulse from the edge logic.
	logic cmp_evt; // Compare match in a compare mode.
	logic do_wr; // A write completes this cycle.
	logic wr_lane; // Byte lane zero is written.
	logic [1:0] rd_resp;
	logic [31:0] rd_data;
	logic stat_clr; // Software clears the flag.

	ecmc_steer_if sif ();

	assign mode = ctrl_r[ecmc_pkg::MODE_LSB +: 4];
	assign mode_chg = mode != mode_q_r;
	assign is_pwm = mode[3:2] == 2'h3;
	assign is_cap = mode[3:2] == 2'h1 || mode == ecmc_pkg::MODE_CAP;
	assign is_cmp = mode == ecmc_pkg::MODE_TOGGLE ||
		mode[3:2] == 2'h2;
	// Reserved mode one is treated as off by every decode.
	assign cmp_evt = compare_match_in && is_cmp && !mode_chg;

	// Write address and data are taken in either order.
	assign s_axi_awready_out = !aw_ok_r && !s_axi_bvalid_out;
	assign s_axi_wready_out = !w_ok_r && !s_axi_bvalid_out;
	assign do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid_out;
	assign wr_lane = do_wr && w_strb_r[0];
	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign stat_clr = wr_lane && aw_addr_r == ecmc_pkg::STAT_OFS &&
		w_data_r[0];

	// Holds write address and data until both are present.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			aw_ok_r <= 1'h0;
			aw_addr_r <= 8'h00;
			w_ok_r <= 1'h0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_ok_r <= 1'h1;
				aw_addr_r <= s_axi_awaddr_in;
			end else if (do_wr) begin
				aw_ok_r <= 1'h0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_ok_r <= 1'h1;
				w_data_r <= s_axi_wdata_in;
				w_strb_r <= s_axi_wstrb_in;
			end else if (do_wr) begin
				w_ok_r <= 1'h0;
			end
		end
	end

	// Write response, an error for an unmapped address.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_axi_bvalid_out <= 1'h0;
			s_axi_bresp_out <= ecmc_pkg::RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid_out <= 1'h1;
			s_axi_bresp_out <= (aw_addr_r[7:4] == 4'h0 &&
				aw_addr_r[1:0] == 2'h0) ? ecmc_pkg::RESP_OKAY :
				ecmc_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'h0;
		end
	end

	// Control, duty and mask registers.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_r <= ecmc_pkg::CTRL_RST;
			duty_r <= ecmc_pkg::DUTY_RST;
			mask_r <= ecmc_pkg::MASK_RST;
		end else if (wr_lane) begin
			unique case (aw_addr_r)
				ecmc_pkg::CTRL_OFS: begin
					ctrl_r <= w_data_r[7:0];
				end
				ecmc_pkg::DUTY_OFS: begin
					duty_r <= w_data_r[7:0];
				end
				ecmc_pkg::MASK_OFS: begin
					mask_r <= w_data_r[0];
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky flag: hardware setting wins over a clear in one cycle.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stat_r <= ecmc_pkg::STAT_RST;
		end else if ((cap_evt && is_cap) || cmp_evt) begin
			stat_r <= 1'h1;
		end else if (stat_clr) begin
			stat_r <= 1'h0;
		end
	end

	assign irq_out = stat_r[0] && mask_r[0];

	// Read data mux; reserved bits read as zero.
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_resp = ecmc_pkg::RESP_OKAY;
		unique case (s_axi_araddr_in)
			ecmc_pkg::CTRL_OFS: rd_data = {24'h0, ctrl_r};
			ecmc_pkg::DUTY_OFS: rd_data = {24'h0, duty_r};
			ecmc_pkg::STAT_OFS: rd_data = {31'h0, stat_r};
			ecmc_pkg::MASK_OFS: rd_data = {31'h0, mask_r};
			default: rd_resp = ecmc_pkg::RESP_SLVERR;
		endcase
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_axi_rvalid_out <= 1'h0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= ecmc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_rvalid_out <= 1'h1;
			s_axi_rdata_out <= rd_data;
			s_axi_rresp_out <= rd_resp;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'h0;
		end
	end

	// Remembers the mode so a change can initialise the pin.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode_q_r <= ecmc_pkg::MODE_OFF;
		end else begin
			mode_q_r <= mode;
		end
	end

	// Compare output level: set on entry, changed on match.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmp_level_r <= 1'h0;
		end else if (mode_chg) begin
			cmp_level_r <= mode == ecmc_pkg::MODE_CLR_ON;
		end else if (compare_match_in) begin
			unique case (mode)
				ecmc_pkg::MODE_TOGGLE: cmp_level_r <= !cmp_level_r;
				ecmc_pkg::MODE_SET_ON: cmp_level_r <= 1'h1;
				ecmc_pkg::MODE_CLR_ON: cmp_level_r <= 1'h0;
				default: cmp_level_r <= cmp_level_r;
			endcase
		end
	end

	// Timer strobes: capture latch and special event reset.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			capture_strobe_out <= 1'h0;
			special_event_out <= 1'h0;
		end else begin
			capture_strobe_out <= cap_evt && is_cap;
			special_event_out <= cmp_evt &&
				mode == ecmc_pkg::MODE_SPECIAL;
		end
	end

	// Timebase run and ten-bit duty, zero outside PWM.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pwm_enable_out <= 1'h0;
			duty_value_out <= 10'h000;
		end else begin
			pwm_enable_out <= is_pwm;
			duty_value_out <= is_pwm ?
				{duty_r, ctrl_r[ecmc_pkg::DUTY_LSB +: 2]} : 10'h000;
		end
	end

	ecmc_capture u_capture (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.clear_in(mode_chg || !is_cap),
		.mode_in(mode),
		.pin_in(capture_pin_in),
		.event_out(cap_evt)
	);

	assign sif.mode = mode;
	assign sif.cfg = ctrl_r[ecmc_pkg::CFG_LSB +: 2];
	assign sif.cmp_level = cmp_level_r;
	// Software-interrupt and special-event modes release the pin.
	assign sif.cmp_own = mode == ecmc_pkg::MODE_TOGGLE ||
		mode == ecmc_pkg::MODE_SET_ON ||
		mode == ecmc_pkg::MODE_CLR_ON;
	assign sif.pwm_raw = pwm_raw_in;
	assign sif.pwm_comp = pwm_comp_in;

	ecmc_steer u_steer (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.sif(sif)
	);

	assign output_a_out = sif.pin[0];
	assign output_b_out = sif.pin[1];
	assign output_c_out = sif.pin[2];
	assign output_d_out = sif.pin[3];
	assign output_own_out = sif.own;

	// Every check below runs on the register clock and rests in reset.
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	a_off_released: assert property (mode == 4'h0 |=>
		output_own_out == 4'h0 && !capture_strobe_out)
		else $error("Unit not released in off mode.");
	a_toggle_pin: assert property (mode == 4'h2 && !mode_chg &&
		compare_match_in |=> cmp_level_r != $past(cmp_level_r))
		else $error("Compare match did not toggle the pin.");
	a_capture_flag: assert property (cap_evt && is_cap |=>
		stat_r[0] && capture_strobe_out)
		else $error("Capture did not set the flag.");
	a_init_low: assert property (mode == 4'h8 && mode_chg |=>
		!cmp_level_r ##1 output_own_out[0] && !output_a_out)
		else $error("Set-on-match mode did not start low.");
	a_init_high: assert property (mode == 4'h9 && mode_chg |=>
		cmp_level_r)
		else $error("Clear-on-match mode did not start high.");
	a_swi_release: assert property (mode == 4'hA |=>
		!output_own_out[0])
		else $error("Software interrupt mode drives the pin.");
	a_special_evt: assert property (cmp_evt && mode == 4'hB |=>
		special_event_out && stat_r[0])
		else $error("Special event trigger missing.");
	a_duty_word: assert property (is_pwm |=> duty_value_out ==
		{$past(duty_r), $past(ctrl_r[5:4])})
		else $error("Duty value does not match registers.");
	a_flag_sticky: assert property (stat_r[0] && !stat_clr |=>
		stat_r[0])
		else $error("Flag dropped without a clear.");
	a_pwm_noflag: assert property (is_pwm && !stat_r[0] && !mode_chg
		|=> !stat_r[0])
		else $error("Flag set in PWM mode.");
	// The flag must rise on a match even while the mask is clear.
	a_flag_unmasked: assert property (cmp_evt && !mask_r[0] |=>
		stat_r[0])
		else $error("Compare match did not set a masked flag.");
	// Off mode stops the timebase and zeroes the duty word.
	a_off_nopwm: assert property (mode == 4'h0 |=>
		!pwm_enable_out && duty_value_out == 10'h000)
		else $error("Timebase still running in off mode.");
	// A capture strobe lasts one cycle, so the timer latches once.
	a_strobe_once: assert property (capture_strobe_out |=>
		!capture_strobe_out)
		else $error("Capture strobe longer than one cycle.");

	// Main scenarios of a full run.
	c_half: cover property (pwm_enable_out && output_own_out == 4'h3);
	c_capture: cover property (capture_strobe_out);
	c_special: cover property (special_event_out);
	c_irq: cover property (!irq_out ##1 irq_out);
	c_bridge: cover property (output_own_out == 4'hF);
endmodule : ecmc_top

/* logic/ecmc_pkg.sv */
// Shared constants and types of the mode and output-steering control.
package ecmc_pkg;
	// Register byte offsets on the AXI4-Lite port.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DUTY_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS = 8'h0C;
	// Field positions inside the mode control register.
	localparam int MODE_LSB = 0;
	localparam int DUTY_LSB = 4;
	localparam int CFG_LSB = 6;
	// Values after reset.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [0:0] STAT_RST = 1'h0;
	localparam logic [0:0] MASK_RST = 1'h0;
	// Edge counts of the prescaled capture modes, minus one.
	localparam logic [3:0] DIV4_LAST = 4'h3;
	localparam logic [3:0] DIV16_LAST = 4'hF;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Encodings of the four-bit mode field.
	typedef enum logic [3:0] {
		MODE_OFF = 4'h0,
		MODE_RSVD = 4'h1,
		MODE_TOGGLE = 4'h2,
		MODE_CAP = 4'h3,
		MODE_CAP_FALL = 4'h4,
		MODE_CAP_RISE = 4'h5,
		MODE_CAP_4 = 4'h6,
		MODE_CAP_16 = 4'h7,
		MODE_SET_ON = 4'h8,
		MODE_CLR_ON = 4'h9,
		MODE_SWI = 4'hA,
		MODE_SPECIAL = 4'hB
	} ecmc_mode_type;
	// Encodings of the output configuration field.
	typedef enum logic [1:0] {
		CFG_SINGLE = 2'h0,
		CFG_FULL_FWD = 2'h1,
		CFG_HALF = 2'h2,
		CFG_FULL_REV = 2'h3
	} ecmc_cfg_type;
endpackage : ecmc_pkg

/* logic/ecmc_steer_if.sv */
`timescale 1ns/1ps
// Signals between the control core and the pin steering stage.
interface ecmc_steer_if;
	logic [3:0] mode; // Current mode field.
	logic [1:0] cfg; // Output configuration field.
	logic cmp_level; // Compare output level.
	logic cmp_own; // Compare logic owns output A.
	logic pwm_raw; // Modulated signal from the timebase.
	logic pwm_comp; // Complement with dead band.
	logic [3:0] pin; // Pin levels, D down to A.
	logic [3:0] own; // Pin owned by the unit, D down to A.
	modport ctrl (output mode, cfg, cmp_level, cmp_own, pwm_raw,
		pwm_comp, input pin, own);
	modport steer (input mode, cfg, cmp_level, cmp_own, pwm_raw,
		pwm_comp, output pin, own);
endinterface : ecmc_steer_if

/* logic/ecmc_capture.sv */
`timescale 1ns/1ps
// Synchronises the capture pin and raises one pulse per capture.
module ecmc_capture (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Control.
	input wire logic clear_in,
	input wire logic [3:0] mode_in,
	// Capture pin, asynchronous.
	input wire logic pin_in,
	// Capture pulse.
	output logic event_out
);
	logic meta_r; // First synchroniser stage.
	logic sync_r; // Second synchroniser stage.
	logic old_r; // Previous synchronised level.
	logic [3:0] cnt_r; // Rising edges seen in a prescale group.
	logic rise;
	logic fall;

	// Two stages before any logic looks at the pin.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
			old_r <= 1'h0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
			old_r <= sync_r;
		end
	end

	assign rise = sync_r && !old_r;
	assign fall = !sync_r && old_r;

	// Counts rising edges and fires on the selected edge.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_r <= 4'h0;
			event_out <= 1'h0;
		end else if (clear_in) begin
			cnt_r <= 4'h0;
			event_out <= 1'h0;
		end else begin
			event_out <= 1'h0;
			unique case (mode_in)
				// Plain capture behaves as falling edge capture.
				ecmc_pkg::MODE_CAP, ecmc_pkg::MODE_CAP_FALL: begin
					event_out <= fall;
				end
				ecmc_pkg::MODE_CAP_RISE: begin
					event_out <= rise;
				end
				ecmc_pkg::MODE_CAP_4, ecmc_pkg::MODE_CAP_16: begin
					if (rise) begin
						if ((mode_in == ecmc_pkg::MODE_CAP_4 &&
							cnt_r == ecmc_pkg::DIV4_LAST) ||
							cnt_r == ecmc_pkg::DIV16_LAST) begin
							cnt_r <= 4'h0;
							event_out <= 1'h1;
						end else begin
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				default: begin
					cnt_r <= 4'h0;
				end
			endcase
		end
	end
endmodule : ecmc_capture

/* logic/ecmc_steer.sv */
`timescale 1ns/1ps
// Drives the four unit outputs from mode, configuration and polarity.
module ecmc_steer (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Core side.
	ecmc_steer_if.steer sif
);
	logic pwm; // The upper mode bits select PWM.
	logic [3:0] act; // Active levels before polarity.
	logic [3:0] own; // Ownership before the register.
	logic [3:0] inv; // Per pin active-low selection.

	assign pwm = sif.mode[3:2] == 2'h3;
	// Mode bit 1 inverts A and C, mode bit 0 inverts B and D.
	assign inv = {sif.mode[0], sif.mode[1], sif.mode[0], sif.mode[1]};

	// Chooses which pins are modulated, held or released.
	always_comb begin
		act = 4'h0;
		own = 4'h0;
		if (!pwm) begin
			act = {3'h0, sif.cmp_level};
			own = {3'h0, sif.cmp_own};
		end else begin
			unique case (sif.cfg)
				ecmc_pkg::CFG_SINGLE: begin
					act = {3'h0, sif.pwm_raw};
					own = 4'h1;
				end
				ecmc_pkg::CFG_FULL_FWD: begin
					act = {sif.pwm_raw, 3'h1};
					own = 4'hF;
				end
				ecmc_pkg::CFG_HALF: begin
					act = {2'h0, sif.pwm_comp, sif.pwm_raw};
					own = 4'h3;
				end
				ecmc_pkg::CFG_FULL_REV: begin
					act = {1'h0, 1'h1, sif.pwm_raw, 1'h0};
					own = 4'hF;
				end
			endcase
		end
	end

	// Pin levels and ownership come from flip-flops.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sif.pin <= 4'h0;
			sif.own <= 4'h0;
		end else begin
			sif.pin <= pwm ? (act ^ inv) : act;
			sif.own <= own;
		end
	end

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);

	a_fwd_bridge: assert property (pwm && sif.cfg == 2'h1 |=>
		sif.own == 4'hF && sif.pin[0] == !$past(sif.mode[1]))
		else $error("Forward bridge does not hold A active.");
	a_rev_bridge: assert property (pwm && sif.cfg == 2'h3 |=>
		sif.pin[2] == !$past(sif.mode[1]))
		else $error("Reverse bridge does not hold C active.");
	a_single_out: assert property (pwm && sif.cfg == 2'h0 |=>
		sif.own == 4'h1)
		else $error("Single output mode drives other pins.");
	a_half_pair: assert property (pwm && sif.cfg == 2'h2 |=>
		sif.pin[1] == ($past(sif.pwm_comp) ^ $past(sif.mode[0])))
		else $error("Half bridge B does not follow complement.");
	a_nonpwm_pins: assert property (!pwm |=> sif.own[3:1] == 3'h0)
		else $error("Port pins taken outside PWM.");
endmodule : ecmc_steer

/* bench/ecmc_far_model.sv */
`timescale 1ns/1ps
// Far side: timer match source, timebase wave and capture pin.
module ecmc_far_model (
	// Clock.
	input wire logic mclk_in,
	// Timer and pin signals.
	output logic match_out,
	output logic raw_out,
	output logic comp_out,
	output logic pin_out
);
	// Idle levels from time zero; the pin idles low.
	initial begin
		match_out = 1'h0;
		raw_out = 1'h0;
		comp_out = 1'h1;
		pin_out = 1'h0;
	end
	// One-cycle compare match pulse.
	task automatic pulse_match();
		@(posedge mclk_in);
		match_out <= 1'h1;
		@(posedge mclk_in);
		match_out <= 1'h0;
	endtask : pulse_match
	// Sets the wave; the complement has no dead band here.
	task automatic set_wave(input logic r);
		@(posedge mclk_in);
		raw_out <= r;
		comp_out <= ~r;
	endtask : set_wave
	// Whole pin pulses, three cycles high and three low.
	task automatic pin_pulses(input int n);
		repeat (n) begin
			@(posedge mclk_in);
			pin_out <= 1'h1;
			repeat (3) @(posedge mclk_in);
			pin_out <= 1'h0;
			repeat (2) @(posedge mclk_in);
		end
	endtask : pin_pulses
endmodule : ecmc_far_model

/* bench/testbench.sv */
`timescale 1ns/1ps
// Self-checking bench of the mode and output-steering control.
module testbench;
	// Clock, reset and bus signals.
	logic mclk_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb, own, m;
	logic [1:0] bresp, rresp, rs, cfg;
	// Far side and pin signals.
	logic match, raw, comp, pin, cap_strobe, sev, pwm_en, a, b, c, d, irq;
	logic [9:0] duty;
	logic [7:0] dh;
	logic own_a;
	// Counters and seed.
	int n_errors, check_count, c0, seed;
	int cap_count = 0;
	int sev_count = 0;
	// Modes under test; reserved mode one is never written.
	logic [3:0] cmp_m [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
	logic [3:0] cap_m [6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
	int cap_n [6] = '{0, 16, 16, 16, 4, 1};
	localparam logic [7:0] CTRL = ecmc_pkg::CTRL_OFS;
	localparam logic [7:0] STAT = ecmc_pkg::STAT_OFS;

	ecmc_top dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .compare_match_in(match),
		.pwm_raw_in(raw), .pwm_comp_in(comp), .capture_pin_in(pin),
		.capture_strobe_out(cap_strobe), .special_event_out(sev),
		.pwm_enable_out(pwm_en), .duty_value_out(duty),
		.output_a_out(a), .output_b_out(b), .output_c_out(c),
		.output_d_out(d), .output_own_out(own), .irq_out(irq));

	ecmc_far_model far_u (.mclk_in(mclk_in), .match_out(match),
		.raw_out(raw), .comp_out(comp), .pin_out(pin));

	// Clock at 200 MHz.
	initial begin
		mclk_in = 1'h0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	// Counts strobe cycles so that a stretched pulse shows up.
	always @(posedge mclk_in) begin
		if (cap_strobe === 1'h1) cap_count <= cap_count + 1;
		if (sev === 1'h1) sev_count <= sev_count + 1;
	end
	// Compares and counts; a mismatch prints at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Waits n edges, then samples at the falling edge.
	task automatic settle(input int n);
		repeat (n) @(posedge mclk_in);
		@(negedge mclk_in);
	endtask : settle
	// Bus write: address and data go out together; each drops when taken.
	task automatic axi_write(input logic [7:0] ad, input logic [31:0] dt);
		logic ap, wp, at, wt, got;
		@(posedge mclk_in);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		ap = 1'h1;
		wp = 1'h1;
		while (ap || wp) begin
			@(negedge mclk_in);
			at = ap && awready;
			wt = wp && wready;
			@(posedge mclk_in);
			if (at) begin
				ap = 1'h0;
				awvalid <= 1'h0;
			end
			if (wt) begin
				wp = 1'h0;
				wvalid <= 1'h0;
			end
		end
		bready <= 1'h1;
		got = 1'h0;
		while (!got) begin
			@(negedge mclk_in);
			got = bvalid;
			rs = bresp;
			@(posedge mclk_in);
		end
		bready <= 1'h0;
	endtask : axi_write
	// Bus read: holds the request until taken, then waits for the answer.
	task automatic axi_read(input logic [7:0] ad);
		logic got;
		@(posedge mclk_in);
		araddr <= ad;
		arvalid <= 1'h1;
		got = 1'h0;
		while (!got) begin
			@(negedge mclk_in);
			got = arready;
			@(posedge mclk_in);
		end
		arvalid <= 1'h0;
		rready <= 1'h1;
		got = 1'h0;
		while (!got) begin
			@(negedge mclk_in);
			got = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge mclk_in);
		end
		rready <= 1'h0;
	endtask : axi_read
	// Expected owned pins and their levels in a PWM mode, D down to A.
	function automatic logic [7:0] pwm_exp(input logic [3:0] md,
		input logic [1:0] cf, input logic r);
		logic [3:0] lv, ow;
		case (cf)
			2'h0: begin
				lv = {3'h0, r};
				ow = 4'h1;
			end
			2'h1: begin
				lv = {r, 2'h0, 1'h1};
				ow = 4'hF;
			end
			2'h2: begin
				lv = {2'h0, ~r, r};
				ow = 4'h3;
			end
			default: begin
				lv = {2'h1, r, 1'h0};
				ow = 4'hF;
			end
		endcase
		lv = lv ^ {md[0], md[1], md[0], md[1]};
		return {ow, lv & ow};
	endfunction : pwm_exp
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	// Cuts a hang short.
	initial begin
		#100000;
		n_errors++;
		complete_run();
	end
	// Main sequence.
	initial begin
		seed = 32'h1905;
		n_errors = 0;
		check_count = 0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		resetn_in = 1'h0;
		repeat (4) @(posedge mclk_in);
		resetn_in <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			axi_read(8'(i * 4));
			chk(rd, 32'h0);
		end
		axi_write(8'h10, 32'h1);
		chk(32'(rs), 32'(ecmc_pkg::RESP_SLVERR));
		axi_read(8'h10);
		chk(32'(rs), 32'(ecmc_pkg::RESP_SLVERR));
		$display("test registers done");
		foreach (cmp_m[i]) begin
			m = cmp_m[i];
			cfg = 2'($random(seed));
			own_a = (m == 4'h2 || m == 4'h8 || m == 4'h9);
			axi_write(STAT, 32'h1);
			axi_write(CTRL, {24'h0, cfg, 2'h0, m});
			settle(2);
			chk(32'(own), {31'h0, own_a});
			if (own_a) chk(32'(a), 32'(m == 4'h9));
			c0 = sev_count;
			far_u.pulse_match();
			settle(2);
			if (own_a) chk(32'(a), 32'(m != 4'h9));
			chk(32'(sev_count - c0), 32'(m == 4'hB));
			chk(32'(irq), 32'h0);
			chk(32'(duty), 32'h0);
			if (m == 4'h2) begin
				far_u.pulse_match();
				settle(2);
				chk(32'(a), 32'h0);
			end
			axi_read(STAT);
			chk(rd, 32'h1);
		end
		axi_write(ecmc_pkg::MASK_OFS, 32'h1);
		settle(1);
		chk(32'(irq), 32'h1);
		axi_write(STAT, 32'h1);
		settle(1);
		chk(32'(irq), 32'h0);
		$display("test compare done");
		foreach (cap_m[i]) begin
			axi_write(CTRL, 32'h0);
			axi_write(STAT, 32'h1);
			axi_write(CTRL, {28'h0, cap_m[i]});
			c0 = cap_count;
			far_u.pin_pulses(16);
			settle(8);
			chk(32'(cap_count - c0), 32'(cap_n[i]));
			axi_read(STAT);
			chk(rd, 32'(cap_n[i] > 0));
		end
		$display("test capture done");
		dh = 8'($random(seed));
		axi_write(ecmc_pkg::DUTY_OFS, {24'h0, dh});
		axi_write(STAT, 32'h1);
		for (int k = 0; k < 32; k++) begin
			m = {2'h3, 2'(k)};
			cfg = 2'(k >> 2);
			wdata <= 32'h0;
			rd = 32'($random(seed));
			axi_write(CTRL, {24'h0, cfg, rd[5:4], m});
			far_u.set_wave(k[4]);
			settle(3);
			chk({24'h0, own, {d, c, b, a} & own},
				{24'h0, pwm_exp(m, cfg, k[4])});
			chk(32'(duty), {22'h0, dh, rd[5:4]});
			chk(32'(pwm_en), 32'h1);
		end
		far_u.pulse_match();
		settle(2);
		axi_read(STAT);
		chk(rd, 32'h0);
		axi_write(CTRL, 32'hF0);
		settle(2);
		chk({17'h0, own, pwm_en, duty}, 32'h0);
		$display("test pwm done");
		complete_run();
	end
endmodule : testbench
